// [src/reset_cause_flags.sv]
// Reset-cause flags, core timeout/power-down status and brown-out control
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module rcf_reset_cause_flags (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire rcf_pkg::rcf_event_t events,
    input wire logic sleeping,
    input wire logic bor_circuit_ready,
    output rcf_pkg::rcf_core_ctl_t core_ctl,
    output logic brownout_enable,
    output logic timeout_status,
    output logic powerdown_status
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] p0_q;
    logic [7:0] p0_d;
    logic viol_q;
    logic viol_d;
    logic sw_en_q;
    logic sw_en_d;
    logic ready_q;
    logic ready_d;
    logic to_q;
    logic to_d;
    logic pdn_q;
    logic pdn_d;
    logic [1:0] mode_q;
    logic [1:0] mode_d;
    logic stk_rst_q;
    logic stk_rst_d;
    logic irq_en_q;
    logic irq_en_d;
    logic bor_en_q;
    logic bor_en_d;
    logic wr_pend_q;
    logic [11:0] wr_idx_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic vec_pend_q;
    logic vec_pend_d;
    rcf_pkg::rcf_core_ctl_t ctl_q;
    rcf_pkg::rcf_core_ctl_t ctl_d;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic addr_phase;
    logic [11:0] addr_idx;
    logic addr_hi_zero;
    logic word_ok;
    logic wr_take;
    logic rd_take;
    logic wr_bc;
    logic wr_p0;
    logic wr_p1;
    logic wr_cf;

    // Address phase accepted on a NONSEQ or SEQ with hready high
    assign addr_phase = hsel & hready & htrans[1];
    assign addr_idx = haddr[rcf_pkg::ADDR_MSB:rcf_pkg::ADDR_LSB];
    assign addr_hi_zero = (haddr[31:rcf_pkg::ADDR_MSB + 1] == 18'h00000);
    assign word_ok = addr_hi_zero & (haddr[1:0] == 2'h0);
    assign wr_take = addr_phase & hwrite & word_ok;
    assign rd_take = addr_phase & ~hwrite;

    // Write strobes in the data phase
    assign wr_bc = wr_pend_q & (wr_idx_q == rcf_pkg::BROWNOUT_CONTROL_IDX);
    assign wr_p0 = wr_pend_q & (wr_idx_q == rcf_pkg::POWER_CONTROL_0_IDX);
    assign wr_p1 = wr_pend_q & (wr_idx_q == rcf_pkg::POWER_CONTROL_1_IDX);
    assign wr_cf = wr_pend_q & (wr_idx_q == rcf_pkg::CORE_CONFIG_IDX);

    // ------------------------------------------------------------
    // Event classification
    // ------------------------------------------------------------
    logic stk_fault;
    logic wdt_reset;
    logic wdt_wake;
    logic ext_sleep;
    logic any_reset;
    logic any_wake;

    // Stack faults reset only when enabled
    assign stk_fault = (events.stk_overflow | events.stk_underflow) & stk_rst_q;
    // Watchdog in sleep wakes instead of resetting
    assign wdt_reset = events.wdt_timeout & ~sleeping;
    assign wdt_wake = events.wdt_timeout & sleeping;
    assign ext_sleep = events.ext_reset_pin & sleeping;
    assign any_reset = events.brownout | wdt_reset | events.ext_reset_pin
        | events.reset_instr | stk_fault | events.mem_violation;
    assign any_wake = ~any_reset & (wdt_wake | (events.irq_wake & sleeping));

    // ------------------------------------------------------------
    // Power control 0 next value
    // ------------------------------------------------------------
    logic [7:0] p0_sw;
    logic [7:0] p0_clr;
    logic [7:0] p0_set;
    logic [7:0] p0_hw;

    // Software write, unimplemented bit forced to zero
    assign p0_sw = wr_p0 ? (hwdata[7:0] & rcf_pkg::P0_IMPL_MASK) : p0_q;
    // Per-cause clear and set masks; other bits untouched
    assign p0_clr = {3'h0, wdt_reset, events.ext_reset_pin, events.reset_instr, 2'h0};
    assign p0_set = {events.stk_overflow, events.stk_underflow, 6'h00};
    assign p0_hw = (p0_sw & ~p0_clr) | p0_set;
    // Brown-out reloads defaults, keeps power-on flag, clears own flag
    assign p0_d = events.brownout
        ? ((p0_sw & rcf_pkg::P0_BOR_KEEP) | rcf_pkg::P0_BOR_VALUE)
        : p0_hw;

    // ------------------------------------------------------------
    // Power control 1 next value
    // ------------------------------------------------------------
    logic viol_sw;

    assign viol_sw = wr_p1 ? hwdata[rcf_pkg::P1_VIOL_BIT] : viol_q;
    // Violation wins; brown-out and a pin reset while awake restore it
    assign viol_d = events.mem_violation ? 1'b0
        : (events.brownout | (events.ext_reset_pin & ~sleeping)) ? 1'b1
        : viol_sw;

    // ------------------------------------------------------------
    // Core status bits
    // ------------------------------------------------------------
    logic to_a;
    logic pdn_a;

    // Interrupt wake and pin reset in sleep give 1/0
    assign to_a = ((events.irq_wake & sleeping) | ext_sleep) ? 1'b1 : to_q;
    assign pdn_a = ((events.irq_wake & sleeping) | ext_sleep) ? 1'b0 : pdn_q;
    // Watchdog clears timeout; in sleep also power-down
    assign to_d = events.brownout ? 1'b1 : (events.wdt_timeout ? 1'b0 : to_a);
    assign pdn_d = events.brownout ? 1'b1 : (wdt_wake ? 1'b0 : pdn_a);

    // ------------------------------------------------------------
    // Brown-out control
    // ------------------------------------------------------------
    logic sw_en_wr;

    assign sw_en_wr = wr_bc ? hwdata[rcf_pkg::BC_SW_EN_BIT] : sw_en_q;
    // Brown-out sets the enable; other resets keep it
    assign sw_en_d = events.brownout ? 1'b1 : sw_en_wr;
    // Protection armed per configured mode
    assign bor_en_d = (mode_q == rcf_pkg::MODE_ALWAYS_ON)
        | ((mode_q == rcf_pkg::MODE_OFF_IN_SLEEP) & ~sleeping)
        | ((mode_q == rcf_pkg::MODE_SOFTWARE) & sw_en_q);
    // Ready only while enabled and the circuit has settled
    assign ready_d = bor_en_q & bor_circuit_ready;

    // Configuration register, reserved bits dropped
    assign mode_d = wr_cf ? hwdata[rcf_pkg::CF_MODE_LSB +: 2] : mode_q;
    assign stk_rst_d = wr_cf ? hwdata[rcf_pkg::CF_STK_RST_BIT] : stk_rst_q;
    assign irq_en_d = wr_cf ? hwdata[rcf_pkg::CF_IRQ_EN_BIT] : irq_en_q;

    // ------------------------------------------------------------
    // Core control: reset, wake and vector
    // ------------------------------------------------------------
    // Vector jump follows the resumed instruction when interrupts on
    assign vec_pend_d = any_wake & events.irq_wake & ~events.wdt_timeout & irq_en_q;
    assign ctl_d.core_reset = any_reset;
    assign ctl_d.wake_resume = any_wake;
    assign ctl_d.pc_load = any_reset | (vec_pend_q & ~any_reset);
    assign ctl_d.pc_addr = any_reset ? rcf_pkg::PC_RESET_ADDR
        : (vec_pend_q ? rcf_pkg::PC_IRQ_VECTOR : rcf_pkg::PC_RESET_ADDR);
    assign ctl_d.push_return = vec_pend_q & ~any_reset;

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [7:0] bc_view;
    logic [7:0] p1_view;
    logic [7:0] st_view;
    logic [7:0] cf_view;

    // Unimplemented positions read zero
    assign bc_view = {sw_en_q, 6'h00, ready_q};
    assign p1_view = {6'h00, viol_q, 1'b0};
    assign st_view = {3'h0, to_q, pdn_q, 3'h0};
    assign cf_view = {4'h0, irq_en_q, stk_rst_q, mode_q};
    assign rdata_d = ~(rd_take & word_ok) ? 32'h00000000
        : (addr_idx == rcf_pkg::BROWNOUT_CONTROL_IDX) ? {24'h000000, bc_view}
        : (addr_idx == rcf_pkg::POWER_CONTROL_0_IDX) ? {24'h000000, p0_q}
        : (addr_idx == rcf_pkg::POWER_CONTROL_1_IDX) ? {24'h000000, p1_view}
        : (addr_idx == rcf_pkg::CORE_STATUS_IDX) ? {24'h000000, st_view}
        : (addr_idx == rcf_pkg::CORE_CONFIG_IDX) ? {24'h000000, cf_view}
        : 32'h00000000;

    // ------------------------------------------------------------
    // Bus pipeline registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q <= 12'h000;
            rdata_q <= 32'h00000000;
        end else begin
            wr_pend_q <= wr_take;
            wr_idx_q <= addr_idx;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Flag registers; power-on values on reset
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            p0_q <= rcf_pkg::P0_POR_VALUE;
            viol_q <= 1'b1;
            to_q <= 1'b1;
            pdn_q <= 1'b1;
            sw_en_q <= 1'b1;
        end else begin
            p0_q <= p0_d;
            viol_q <= viol_d;
            to_q <= to_d;
            pdn_q <= pdn_d;
            sw_en_q <= sw_en_d;
        end
    end

    // ------------------------------------------------------------
    // Configuration and brown-out status registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= rcf_pkg::MODE_RESET;
            stk_rst_q <= 1'b1;
            irq_en_q <= 1'b0;
            bor_en_q <= 1'b0;
            ready_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            stk_rst_q <= stk_rst_d;
            irq_en_q <= irq_en_d;
            bor_en_q <= bor_en_d;
            ready_q <= ready_d;
        end
    end

    // ------------------------------------------------------------
    // Core control pulses
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl_q <= '0;
            vec_pend_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            vec_pend_q <= vec_pend_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs from flops, except hreadyout and hresp tied constant
    // ------------------------------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign core_ctl = ctl_q;
    assign brownout_enable = bor_en_q;
    assign timeout_status = to_q;
    assign powerdown_status = pdn_q;

endmodule

// [src/rcf_pkg.sv]
// Constants, field layouts and carrier types for the reset-cause flag block
package rcf_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [11:0] BROWNOUT_CONTROL_IDX = 12'h811;
    localparam logic [11:0] POWER_CONTROL_0_IDX = 12'h813;
    localparam logic [11:0] POWER_CONTROL_1_IDX = 12'h814;
    localparam logic [11:0] CORE_STATUS_IDX = 12'h815;
    localparam logic [11:0] CORE_CONFIG_IDX = 12'h816;
    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 13;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BC_SW_EN_BIT = 7;
    localparam int BC_READY_BIT = 0;
    localparam int P0_OVF_BIT = 7;
    localparam int P0_UNF_BIT = 6;
    localparam int P0_WDT_BIT = 4;
    localparam int P0_EXT_BIT = 3;
    localparam int P0_INSTR_BIT = 2;
    localparam int P0_POR_BIT = 1;
    localparam int P0_BOR_BIT = 0;
    localparam int P1_VIOL_BIT = 1;
    localparam int ST_TO_BIT = 4;
    localparam int ST_PDN_BIT = 3;
    localparam int CF_MODE_LSB = 0;
    localparam int CF_STK_RST_BIT = 2;
    localparam int CF_IRQ_EN_BIT = 3;

    // ------------------------------------------------------------
    // Masks and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] P0_IMPL_MASK = 8'hdf;
    localparam logic [7:0] P0_POR_VALUE = 8'h1d;
    localparam logic [7:0] P0_BOR_VALUE = 8'h1c;
    localparam logic [7:0] P0_BOR_KEEP = 8'h02;
    localparam logic [1:0] MODE_ALWAYS_OFF = 2'h0;
    localparam logic [1:0] MODE_SOFTWARE = 2'h1;
    localparam logic [1:0] MODE_OFF_IN_SLEEP = 2'h2;
    localparam logic [1:0] MODE_ALWAYS_ON = 2'h3;
    localparam logic [1:0] MODE_RESET = 2'h3;
    localparam logic [14:0] PC_RESET_ADDR = 15'h0000;
    localparam logic [14:0] PC_IRQ_VECTOR = 15'h0004;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic brownout;
        logic wdt_timeout;
        logic ext_reset_pin;
        logic reset_instr;
        logic stk_overflow;
        logic stk_underflow;
        logic mem_violation;
        logic irq_wake;
    } rcf_event_t;

    typedef struct packed {
        logic core_reset;
        logic wake_resume;
        logic pc_load;
        logic [14:0] pc_addr;
        logic push_return;
    } rcf_core_ctl_t;

endpackage

// [testbench/rcf_monitor.sv]
// Port-level assertions for the reset-cause flag block
`timescale 1ns/1ns
module rcf_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire rcf_pkg::rcf_event_t events,
    input wire logic sleeping,
    input wire logic bor_circuit_ready,
    input wire rcf_pkg::rcf_core_ctl_t core_ctl,
    input wire logic brownout_enable,
    input wire logic timeout_status,
    input wire logic powerdown_status
);
    // ------------------------------------------------------------
    // Status, read data and core control checks
    // ------------------------------------------------------------
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_por_status: assert property ($rose(hresetn) |-> timeout_status && powerdown_status)
        else $error("status not set after power-on");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("unimplemented read bits not zero");
    a_wdt_status: assert property (events.wdt_timeout && !events.brownout |=> !timeout_status)
        else $error("watchdog left timeout set");
    a_pin_sleep: assert property (events == 8'h20 && sleeping |=> timeout_status && !powerdown_status)
        else $error("pin reset in sleep status wrong");
    a_wdt_wake: assert property (events == 8'h40 && sleeping |=> !timeout_status && !powerdown_status)
        else $error("watchdog wake status wrong");
    a_irq_wake: assert property (events == 8'h01 && sleeping |=>
        (timeout_status && !powerdown_status) ##[0:1] core_ctl.wake_resume)
        else $error("interrupt wake status or resume wrong");
    a_reset_vector: assert property ((events & 8'h32) != 8'h0 || (events.wdt_timeout && !sleeping)
        |-> ##[1:2] (core_ctl.core_reset && core_ctl.pc_load && core_ctl.pc_addr == 15'h0))
        else $error("reset did not load address zero");
    a_status_hold: assert property (events == 8'h0 |=>
        $stable(timeout_status) && $stable(powerdown_status))
        else $error("status changed without an event");
    a_ctl_quiet: assert property (events == 8'h0 ##1 events == 8'h0 |=> core_ctl == '0)
        else $error("core control pulse without an event");
endmodule

bind rcf_reset_cause_flags rcf_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .events, .sleeping,
    .bor_circuit_ready, .core_ctl, .brownout_enable, .timeout_status, .powerdown_status);

// [testbench/tb_rcf_reset_cause_flags.sv]
// Self-checking bench for the reset-cause flag block
`timescale 1ns/1ns
module tb_rcf_reset_cause_flags;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    rcf_pkg::rcf_event_t events = '0;
    logic sleeping = 1'b0;
    logic bor_circuit_ready = 1'b1;
    rcf_pkg::rcf_core_ctl_t core_ctl;
    logic brownout_enable;
    logic timeout_status;
    logic powerdown_status;
    int failures = 0;
    int samples_checked = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic [2:0] seen;
    logic [14:0] pc;
    localparam logic [11:0] BC = rcf_pkg::BROWNOUT_CONTROL_IDX;
    localparam logic [11:0] P0 = rcf_pkg::POWER_CONTROL_0_IDX;
    localparam logic [11:0] P1 = rcf_pkg::POWER_CONTROL_1_IDX;
    localparam logic [11:0] ST = rcf_pkg::CORE_STATUS_IDX;
    localparam logic [11:0] CF = rcf_pkg::CORE_CONFIG_IDX;
    // Event rows: event, config, expected power control 0, status, core control
    localparam logic [7:0] EV [11] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h08, 8'h02, 8'h40,
        8'h01, 8'h80, 8'h20};
    localparam logic [7:0] CFG [11] = '{8'h07, 8'h07, 8'h07, 8'h07, 8'h07, 8'h03, 8'h07, 8'h07,
        8'h0f, 8'h07, 8'h07};
    localparam logic [7:0] XP0 [11] = '{8'h0f, 8'h17, 8'h1b, 8'h9f, 8'h5f, 8'h9f, 8'h1f, 8'h1f,
        8'h1f, 8'h1e, 8'h17};
    localparam logic [1:0] XST [11] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h2,
        2'h3, 2'h2};
    localparam logic [2:0] XCT [11] = '{3'h4, 3'h4, 3'h4, 3'h4, 3'h4, 3'h0, 3'h4, 3'h2, 3'h3,
        3'h4, 3'h4};
    localparam logic [10:0] SLP = 11'h580;

    rcf_reset_cause_flags dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .events, .sleeping,
        .bor_circuit_ready, .core_ctl, .brownout_enable, .timeout_status, .powerdown_status);

    // ------------------------------------------------------------
    // Clock, timeout and helpers
    // ------------------------------------------------------------
    always #25 hclk = ~hclk;

    // Hang guard
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask

    // One AHB-Lite single transfer; read data lands in rd
    task automatic xfer(input logic wr, input logic [11:0] idx, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {18'h0, idx, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic rchk(input string n, input logic [11:0] idx, input logic [7:0] e);
        xfer(1'b0, idx, 8'h0);
        check(n, rd, {24'h0, e});
    endtask

    // One-cycle event, then gather core control pulses
    task automatic pulse(input logic [7:0] ev);
        @(posedge hclk);
        events <= ev;
        @(posedge hclk);
        events <= '0;
        seen = 3'h0;
        pc = 15'h7fff;
        repeat (3) begin
            @(posedge hclk);
            seen = seen | {core_ctl.core_reset, core_ctl.wake_resume, core_ctl.push_return};
            if (core_ctl.pc_load === 1'b1) pc = core_ctl.pc_addr;
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("status_pins", 32'({timeout_status, powerdown_status}), 32'h3);
        rchk("p0_por", P0, 8'h1d);
        rchk("p1_por", P1, 8'h02);
        rchk("st_por", ST, 8'h18);
        rchk("bc_por", BC, 8'h81);
        rchk("unmapped", 12'h812, 8'h00);
        xfer(1'b1, ST, 8'h00);
        rchk("st_ro", ST, 8'h18);
        xfer(1'b1, P0, 8'hff);
        rchk("p0_set", P0, 8'hdf);
        xfer(1'b1, P0, 8'h00);
        rchk("p0_clr", P0, 8'h00);
        for (int i = 0; i < 11; i++) begin
            xfer(1'b1, CF, CFG[i]);
            xfer(1'b1, P0, (i == 9) ? 8'hdf : 8'h1f);
            xfer(1'b1, P1, 8'h02);
            sleeping <= SLP[i];
            pulse(EV[i]);
            check("ctl", 32'(seen), 32'(XCT[i]));
            if (XCT[i][2] | XCT[i][0]) check("pc", 32'(pc), XCT[i][0] ? 32'h4 : 32'h0);
            check("st", 32'({timeout_status, powerdown_status}), 32'(XST[i]));
            sleeping <= 1'b0;
            rchk("p0_evt", P0, XP0[i]);
            rchk("p1_evt", P1, (i == 6) ? 8'h00 : 8'h02);
        end
        xfer(1'b1, CF, 8'h05);
        xfer(1'b1, BC, 8'h7f);
        repeat (4) @(posedge hclk);
        rchk("bc_sw0", BC, 8'h00);
        check("en_sw0", 32'(brownout_enable), 32'h0);
        xfer(1'b1, BC, 8'h80);
        repeat (4) @(posedge hclk);
        rchk("bc_sw1", BC, 8'h81);
        check("en_sw1", 32'(brownout_enable), 32'h1);
        bor_circuit_ready <= 1'b0;
        repeat (4) @(posedge hclk);
        rchk("bc_warm", BC, 8'h80);
        bor_circuit_ready <= 1'b1;
        xfer(1'b1, CF, 8'h04);
        repeat (4) @(posedge hclk);
        check("en_off", 32'(brownout_enable), 32'h0);
        rchk("bc_off", BC, 8'h80);
        xfer(1'b1, CF, 8'h05);
        xfer(1'b1, BC, 8'h00);
        pulse(8'h10);
        repeat (4) @(posedge hclk);
        rchk("bc_keep", BC, 8'h00);
        pulse(8'h80);
        repeat (4) @(posedge hclk);
        rchk("bc_bor", BC, 8'h81);
        check("en_bor", 32'(brownout_enable), 32'h1);
        conclude();
    end
endmodule
